/* File: pkg/spc_map.svh */
// constants of the stepper pulse controller: timing, selectors, pin slots
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH
`define SPC_CLK_HZ      32'd250000000
`define SPC_MAX_PPS     14'd10000
`define SPC_RATE_SHIFT  3
`define SPC_PULSE_NS    32'd10000
`define SPC_PULSE_CYC   (`SPC_PULSE_NS * (`SPC_CLK_HZ / 32'd1000000) / 32'd1000)
`define SPC_PF_SOURCE   8'h11
`define SPC_SEL_CH1     8'h01
`define SPC_SEL_CH2     8'h02
`define SPC_SEL_CH2_ALT 8'h20
`define SPC_SEL_FULL1   8'h0b
`define SPC_SEL_HALF1   8'h15
`define SPC_HALF_TABLE  32'h98c46231
`define SPC_PIN_DIR1    0
`define SPC_PIN_PUL1    1
`define SPC_PIN_DIR2    2
`define SPC_PIN_PUL2    3
`endif

/* File: pkg/spc_pkg.sv */
// types shared by the stepper pulse controller files
package spc_pkg;
  typedef enum logic [1:0] {
    SPC_MODE_CTRL = 2'h0,
    SPC_MODE_FULL = 2'h1,
    SPC_MODE_HALF = 2'h2
  } spc_mode_t;
  typedef enum logic [2:0] {
    SPC_OP_NONE  = 3'h0,
    SPC_OP_SPEED = 3'h1,
    SPC_OP_REL   = 3'h2,
    SPC_OP_ABS   = 3'h3,
    SPC_OP_STOP  = 3'h4,
    SPC_OP_INTR  = 3'h5
  } spc_op_t;
  typedef enum logic [1:0] {
    SPC_ST_IDLE = 2'h0,
    SPC_ST_RUN  = 2'h1,
    SPC_ST_RAMP = 2'h2
  } spc_state_t;
endpackage

/* File: rtl/spc_step_gen.sv */
// step rate generator: phase accumulator and fixed-width step pulse
`timescale 1ns/10ps
`include "spc_map.svh"
module spc_step_gen #(
  parameter logic [31:0] CLK_HZ    = `SPC_CLK_HZ,
  parameter logic [13:0] MAX_PPS   = `SPC_MAX_PPS,
  parameter logic [31:0] PULSE_CYC = `SPC_PULSE_CYC
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // rate control
  input  wire logic        run,
  input  wire logic [13:0] rate,
  // step outputs
  output logic             stepTick,
  output logic             stepPulse
);
  localparam int unsigned MIN_GAP = CLK_HZ / {18'h0, MAX_PPS};

  logic [31:0] phaseReg;
  logic [31:0] phaseNext;
  logic [31:0] phaseSum;
  logic [31:0] widthReg;
  logic [31:0] widthNext;
  logic        pulseReg;
  logic        pulseNext;

  assign phaseSum  = phaseReg + {18'h0, rate};
  assign stepTick  = run && (phaseSum >= CLK_HZ);
  assign stepPulse = pulseReg;

  always_comb begin
    // idle clears the phase so a new move waits one full interval first
    phaseNext = 32'h0;
    widthNext = widthReg;
    pulseNext = pulseReg;
    if (run) begin
      phaseNext = stepTick ? phaseSum - CLK_HZ : phaseSum;
    end
    if (stepTick) begin
      pulseNext = 1'b1;
      widthNext = PULSE_CYC - 32'h1;
    end else if (widthReg != 32'h0) begin
      widthNext = widthReg - 32'h1;
    end else begin
      pulseNext = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      phaseReg <= 32'h0;
      widthReg <= 32'h0;
      pulseReg <= 1'b0;
    end else begin
      phaseReg <= phaseNext;
      widthReg <= widthNext;
      pulseReg <= pulseNext;
    end
  end

  // helper counters for the checks below
  logic [31:0] gapCnt;
  logic [31:0] highCnt;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      gapCnt  <= 32'h0;
      highCnt <= 32'h0;
    end else begin
      gapCnt  <= (!run || stepTick) ? 32'h0 : gapCnt + 32'h1;
      highCnt <= pulseReg ? highCnt + 32'h1 : 32'h0;
    end
  end

  a_step_gap: assert property (@(posedge clk_sys) disable iff (!reset_n)
    stepTick |-> gapCnt + 32'h1 >= MIN_GAP)
    else $error("step interval shorter than the top rate allows");
  a_pulse_width: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $fell(pulseReg) |-> $past(highCnt) + 32'h1 == PULSE_CYC)
    else $error("step pulse width wrong");
endmodule

/* File: rtl/spc_stepper_ctrl.sv */
// two-channel stepper pulse controller with direct unipolar driver and power-fail event
`timescale 1ns/10ps
`include "spc_map.svh"
module spc_stepper_ctrl #(
  parameter logic [31:0] CLK_HZ  = `SPC_CLK_HZ,
  parameter logic [13:0] MAX_PPS = `SPC_MAX_PPS
) (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  // command port
  input  wire logic                   cmdValid,
  input  wire spc_pkg::spc_op_t       cmdOp,
  input  wire logic [7:0]             cmdSel,
  input  wire logic signed [31:0]     cmdValue,
  input  wire logic [13:0]            cmdSpeed,
  input  wire logic [31:0]            cmdAccel,
  output logic                        cmdAck,
  output logic                        cmdOk,
  // general outputs five to eight
  input  wire logic [3:0]             progOut,
  output logic [3:0]                  pinOut,
  // power-fail event
  input  wire logic                   powerFailSense,
  output logic                        isrStart,
  output logic [7:0]                  isrSource,
  output logic [7:0]                  isrFunc,
  // channel status
  output logic                        busyCh1,
  output logic                        busyCh2,
  output logic                        doneCh1,
  output logic                        doneCh2,
  output logic signed [31:0]          absPosCh1,
  output logic signed [31:0]          absPosCh2,
  output logic signed [31:0]          relCountCh1,
  output logic signed [31:0]          relCountCh2
);
  localparam logic [31:0] HALF_TABLE = `SPC_HALF_TABLE;

  function automatic logic [13:0] minRate(input logic [13:0] maxPps);
    minRate = ((maxPps >> `SPC_RATE_SHIFT) == 14'h0) ? 14'h1 : (maxPps >> `SPC_RATE_SHIFT);
  endfunction
  function automatic logic [3:0] coilPattern(input logic [2:0] idx);
    coilPattern = HALF_TABLE[{idx, 2'h0} +: 4];
  endfunction
  // result is {valid, channel, mode}
  function automatic logic [3:0] decodeSel(input logic [7:0] sel);
    if (sel == `SPC_SEL_CH1) begin
      decodeSel = {2'h2, spc_pkg::SPC_MODE_CTRL};
    end else if (sel == `SPC_SEL_CH2 || sel == `SPC_SEL_CH2_ALT) begin
      decodeSel = {2'h3, spc_pkg::SPC_MODE_CTRL};
    end else if (sel == `SPC_SEL_FULL1) begin
      decodeSel = {2'h2, spc_pkg::SPC_MODE_FULL};
    end else if (sel == `SPC_SEL_HALF1) begin
      decodeSel = {2'h2, spc_pkg::SPC_MODE_HALF};
    end else begin
      decodeSel = 4'h0;
    end
  endfunction

  spc_pkg::spc_state_t stateReg [2];
  spc_pkg::spc_state_t stateNext [2];
  spc_pkg::spc_mode_t  modeReg [2];
  spc_pkg::spc_mode_t  modeNext [2];
  logic [31:0]         remReg [2];
  logic [31:0]         remNext [2];
  logic [31:0]         upReg [2];
  logic [31:0]         upNext [2];
  logic [31:0]         accReg [2];
  logic [31:0]         accNext [2];
  logic signed [31:0]  posReg [2];
  logic signed [31:0]  posNext [2];
  logic signed [31:0]  relReg [2];
  logic signed [31:0]  relNext [2];
  logic signed [32:0]  errReg [2];
  logic signed [32:0]  errNext [2];
  logic [13:0]         rateReg [2];
  logic [13:0]         rateNext [2];
  logic [13:0]         maxReg [2];
  logic [13:0]         maxNext [2];
  logic [2:0]          idxReg [2];
  logic [2:0]          idxNext [2];
  logic                dirReg [2];
  logic                dirNext [2];
  logic                doneReg [2];
  logic                doneNext [2];
  logic                riseReg [2];
  logic                riseNext [2];
  logic                tick [2];
  logic                pulse [2];
  logic [1:0]          startCh;
  logic [1:0]          stopCh;
  logic [1:0]          speedCh;
  logic [3:0]          selInfo;
  logic                selValid;
  logic                selChan;
  spc_pkg::spc_mode_t  selMode;
  logic                ch1Driver;
  logic                own1Reg, own1Next, own2Reg, own2Next;
  logic                ackNext, okNext, pfPrevReg, isrNext, pfDefReg, pfDefNext;
  logic [7:0]          pfFuncReg, pfFuncNext;
  logic [3:0]          pinNext;

  assign selInfo   = decodeSel(cmdSel);
  assign selValid  = selInfo[3];
  assign selChan   = selInfo[2];
  assign selMode   = spc_pkg::spc_mode_t'(selInfo[1:0]);
  assign ch1Driver = own1Reg && (modeReg[0] != spc_pkg::SPC_MODE_CTRL);
  assign isrSource = `SPC_PF_SOURCE;
  assign isrFunc   = pfFuncReg;
  assign busyCh1   = (stateReg[0] != spc_pkg::SPC_ST_IDLE);
  assign busyCh2   = (stateReg[1] != spc_pkg::SPC_ST_IDLE);
  assign doneCh1   = doneReg[0];
  assign doneCh2   = doneReg[1];
  assign absPosCh1 = posReg[0];
  assign absPosCh2 = posReg[1];
  assign relCountCh1 = relReg[0];
  assign relCountCh2 = relReg[1];

  // command decode, pin ownership, power-fail event
  always_comb begin
    startCh    = 2'h0;
    stopCh     = 2'h0;
    speedCh    = 2'h0;
    ackNext    = cmdValid;
    okNext     = 1'b0;
    own1Next   = own1Reg;
    own2Next   = own2Reg;
    pfFuncNext = pfFuncReg;
    pfDefNext  = pfDefReg;
    isrNext    = powerFailSense && !pfPrevReg && pfDefReg;
    if (cmdValid) begin
      if (cmdOp == spc_pkg::SPC_OP_INTR) begin
        if (cmdSel == `SPC_PF_SOURCE) begin
          pfFuncNext = cmdValue[7:0];
          pfDefNext  = 1'b1;
          okNext     = 1'b1;
        end
      end else if (selValid) begin
        if (cmdOp == spc_pkg::SPC_OP_STOP) begin
          stopCh[selChan] = 1'b1;
          okNext          = 1'b1;
        end else if (cmdOp == spc_pkg::SPC_OP_SPEED) begin
          if (selMode == spc_pkg::SPC_MODE_CTRL && stateReg[selChan] == spc_pkg::SPC_ST_IDLE) begin
            speedCh[selChan] = 1'b1;
            okNext           = 1'b1;
          end
        end else if (cmdOp == spc_pkg::SPC_OP_REL || cmdOp == spc_pkg::SPC_OP_ABS) begin
          // a busy channel ignores moves; pins held by the other channel refuse them
          if (stateReg[selChan] == spc_pkg::SPC_ST_IDLE &&
              !(selChan ? ch1Driver : (selMode != spc_pkg::SPC_MODE_CTRL && own2Reg))) begin
            startCh[selChan] = 1'b1;
            okNext           = 1'b1;
            if (selChan) begin
              own2Next = 1'b1;
            end else begin
              own1Next = 1'b1;
            end
          end
        end
      end
    end
    // once a channel owns its pins the program value no longer reaches them
    pinNext = progOut;
    if (ch1Driver) begin
      pinNext = coilPattern(idxReg[0]);
    end else begin
      if (own1Reg) begin
        pinNext[`SPC_PIN_DIR1] = dirReg[0];
        pinNext[`SPC_PIN_PUL1] = pulse[0];
      end
      if (own2Reg) begin
        pinNext[`SPC_PIN_DIR2] = dirReg[1];
        pinNext[`SPC_PIN_PUL2] = pulse[1];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cmdAck    <= 1'b0;
      cmdOk     <= 1'b0;
      own1Reg   <= 1'b0;
      own2Reg   <= 1'b0;
      pfFuncReg <= 8'h0;
      pfDefReg  <= 1'b0;
      pfPrevReg <= 1'b0;
      isrStart  <= 1'b0;
      pinOut    <= 4'h0;
    end else begin
      cmdAck    <= ackNext;
      cmdOk     <= okNext;
      own1Reg   <= own1Next;
      own2Reg   <= own2Next;
      pfFuncReg <= pfFuncNext;
      pfDefReg  <= pfDefNext;
      pfPrevReg <= powerFailSense;
      isrStart  <= isrNext;
      pinOut    <= pinNext;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  a_pf_isr_start: assert property ($rose(powerFailSense) && pfDefReg && pfPrevReg == $past(powerFailSense)
    |=> isrStart && isrFunc == $past(pfFuncReg) && isrSource == `SPC_PF_SOURCE)
    else $error("power-fail edge did not start its service routine");
  a_ch2_ctrl_only: assert property (busyCh2 |-> modeReg[1] == spc_pkg::SPC_MODE_CTRL)
    else $error("channel two left controller mode");
  a_driver_pins: assert property (ch1Driver |=> pinOut == coilPattern($past(idxReg[0])))
    else $error("driver pins not following coil phase");
  a_ctrl_pins: assert property (own1Reg && !ch1Driver
    |=> pinOut[1:0] == {$past(pulse[0]), $past(dirReg[0])})
    else $error("channel one outputs not owned by the stepper");
  a_busy_ignore: assert property (cmdValid && cmdOp == spc_pkg::SPC_OP_REL && selValid
    && stateReg[selChan] != spc_pkg::SPC_ST_IDLE |=> cmdAck && !cmdOk)
    else $error("move accepted while channel busy");
  c_pf_event: cover property (isrStart);
  c_driver_move: cover property (ch1Driver && tick[0]);

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic signed [32:0] moveCnt;
    logic [32:0]        moveMag;
    logic [13:0]        minR;
    logic [13:0]        spanR;
    logic [2:0]         idxStep;

    assign moveCnt = (cmdOp == spc_pkg::SPC_OP_ABS) ?
                     {cmdValue[31], cmdValue} - {posReg[ch][31], posReg[ch]} :
                     {cmdValue[31], cmdValue};
    assign moveMag = moveCnt[32] ? $unsigned(-moveCnt) : $unsigned(moveCnt);
    assign minR    = minRate(maxReg[ch]);
    assign spanR   = maxReg[ch] - minR;
    assign idxStep = (modeReg[ch] == spc_pkg::SPC_MODE_HALF) ? 3'h1 : 3'h2;

    spc_step_gen #(
      .CLK_HZ    (CLK_HZ),
      .MAX_PPS   (MAX_PPS),
      .PULSE_CYC (`SPC_PULSE_CYC)
    ) u_gen (
      .clk_sys   (clk_sys),
      .reset_n   (reset_n),
      .run       (stateReg[ch] != spc_pkg::SPC_ST_IDLE),
      .rate      (rateReg[ch]),
      .stepTick  (tick[ch]),
      .stepPulse (pulse[ch])
    );

    always_comb begin
      stateNext[ch] = stateReg[ch];
      modeNext[ch]  = modeReg[ch];
      remNext[ch]   = remReg[ch];
      upNext[ch]    = upReg[ch];
      accNext[ch]   = accReg[ch];
      posNext[ch]   = posReg[ch];
      relNext[ch]   = relReg[ch];
      errNext[ch]   = errReg[ch];
      rateNext[ch]  = rateReg[ch];
      maxNext[ch]   = maxReg[ch];
      idxNext[ch]   = idxReg[ch];
      dirNext[ch]   = dirReg[ch];
      doneNext[ch]  = doneReg[ch];
      riseNext[ch]  = riseReg[ch];
      if (speedCh[ch]) begin
        maxNext[ch] = (cmdSpeed > MAX_PPS) ? MAX_PPS :
                      ((cmdSpeed == 14'h0) ? 14'h1 : cmdSpeed);
        accNext[ch] = cmdAccel;
      end
      case (stateReg[ch])
        spc_pkg::SPC_ST_IDLE: begin
          if (startCh[ch]) begin
            modeNext[ch] = selMode;
            doneNext[ch] = 1'b0;
            relNext[ch]  = 32'sh0;
            upNext[ch]   = 32'h0;
            errNext[ch]  = 33'sh0;
            dirNext[ch]  = moveCnt[32];
            remNext[ch]  = moveMag[31:0];
            rateNext[ch] = (accReg[ch] == 32'h0) ? maxReg[ch] : minR;
            if (selMode == spc_pkg::SPC_MODE_FULL) begin
              idxNext[ch] = {idxReg[ch][2:1], 1'b0};
            end
            if (moveMag == 33'h0) begin
              doneNext[ch] = 1'b1;
            end else begin
              stateNext[ch] = spc_pkg::SPC_ST_RUN;
            end
          end
        end
        spc_pkg::SPC_ST_RUN: begin
          if (stopCh[ch]) begin
            stateNext[ch] = spc_pkg::SPC_ST_IDLE;
          end else if (tick[ch]) begin
            remNext[ch] = remReg[ch] - 32'h1;
            posNext[ch] = dirReg[ch] ? posReg[ch] - 32'sh1 : posReg[ch] + 32'sh1;
            relNext[ch] = dirReg[ch] ? relReg[ch] - 32'sh1 : relReg[ch] + 32'sh1;
            idxNext[ch] = dirReg[ch] ? idxReg[ch] - idxStep : idxReg[ch] + idxStep;
            if (remReg[ch] == 32'h1) begin
              doneNext[ch]  = 1'b1;
              stateNext[ch] = spc_pkg::SPC_ST_IDLE;
            end else if (remReg[ch] - 32'h1 <= upReg[ch] && upReg[ch] != 32'h0) begin
              // retrace the climb; the last step runs at the floor rate except in even moves of at most twice acc steps
              upNext[ch]    = upReg[ch] - 32'h1;
              errNext[ch]   = errReg[ch] - $signed({19'h0, spanR});
              riseNext[ch]  = 1'b0;
              stateNext[ch] = spc_pkg::SPC_ST_RAMP;
            end else if (upReg[ch] < accReg[ch]) begin
              upNext[ch]    = upReg[ch] + 32'h1;
              errNext[ch]   = errReg[ch] + $signed({19'h0, spanR});
              riseNext[ch]  = 1'b1;
              stateNext[ch] = spc_pkg::SPC_ST_RAMP;
            end
          end
        end
        spc_pkg::SPC_ST_RAMP: begin
          // spreads span over acc steps; takes far fewer cycles than one step interval
          if (stopCh[ch]) begin
            stateNext[ch] = spc_pkg::SPC_ST_IDLE;
          end else if (riseReg[ch] && errReg[ch] >= $signed({1'b0, accReg[ch]})) begin
            errNext[ch]  = errReg[ch] - $signed({1'b0, accReg[ch]});
            rateNext[ch] = rateReg[ch] + 14'h1;
          end else if (!riseReg[ch] && errReg[ch] < 33'sh0) begin
            errNext[ch]  = errReg[ch] + $signed({1'b0, accReg[ch]});
            rateNext[ch] = rateReg[ch] - 14'h1;
          end else begin
            stateNext[ch] = spc_pkg::SPC_ST_RUN;
          end
        end
        default: stateNext[ch] = spc_pkg::SPC_ST_IDLE;
      endcase
    end

    always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
        stateReg[ch] <= spc_pkg::SPC_ST_IDLE;
        modeReg[ch]  <= spc_pkg::SPC_MODE_CTRL;
        remReg[ch]   <= 32'h0;
        upReg[ch]    <= 32'h0;
        accReg[ch]   <= 32'h0;
        posReg[ch]   <= 32'sh0;
        relReg[ch]   <= 32'sh0;
        errReg[ch]   <= 33'sh0;
        rateReg[ch]  <= 14'h1;
        maxReg[ch]   <= 14'h1;
        idxReg[ch]   <= 3'h0;
        dirReg[ch]   <= 1'b0;
        doneReg[ch]  <= 1'b0;
        riseReg[ch]  <= 1'b0;
      end else begin
        stateReg[ch] <= stateNext[ch];
        modeReg[ch]  <= modeNext[ch];
        remReg[ch]   <= remNext[ch];
        upReg[ch]    <= upNext[ch];
        accReg[ch]   <= accNext[ch];
        posReg[ch]   <= posNext[ch];
        relReg[ch]   <= relNext[ch];
        errReg[ch]   <= errNext[ch];
        rateReg[ch]  <= rateNext[ch];
        maxReg[ch]   <= maxNext[ch];
        idxReg[ch]   <= idxNext[ch];
        dirReg[ch]   <= dirNext[ch];
        doneReg[ch]  <= doneNext[ch];
        riseReg[ch]  <= riseNext[ch];
      end
    end

    a_rate_window: assert property (stateReg[ch] == spc_pkg::SPC_ST_RUN
      |-> rateReg[ch] >= minR && rateReg[ch] <= maxReg[ch])
      else $error("step rate outside the ramp window");
    a_pos_track: assert property (stateReg[ch] == spc_pkg::SPC_ST_RUN && tick[ch] && !stopCh[ch]
      |=> posReg[ch] == $past(posReg[ch]) + ($past(dirReg[ch]) ? -32'sh1 : 32'sh1))
      else $error("position not tracking emitted steps");
    a_done_last: assert property (stateReg[ch] == spc_pkg::SPC_ST_RUN && tick[ch]
      && !stopCh[ch] && remReg[ch] == 32'h1 |=> doneReg[ch] && stateReg[ch] == spc_pkg::SPC_ST_IDLE)
      else $error("done flag not set after last pulse");
    a_dir_stable: assert property (stateReg[ch] != spc_pkg::SPC_ST_IDLE
      && $past(stateReg[ch]) != spc_pkg::SPC_ST_IDLE |-> $stable(dirReg[ch]))
      else $error("direction changed during a move");
    a_half_order: assert property (modeReg[ch] == spc_pkg::SPC_MODE_HALF && tick[ch]
      && stateReg[ch] == spc_pkg::SPC_ST_RUN && !stopCh[ch]
      |=> idxReg[ch] == $past(idxReg[ch]) + ($past(dirReg[ch]) ? 3'h7 : 3'h1))
      else $error("coil phase order wrong");
    a_speed_clamp: assert property (speedCh[ch]
      |=> maxReg[ch] >= 14'h1 && maxReg[ch] <= MAX_PPS)
      else $error("speed setting out of range");
    c_ramp_down: cover property (riseReg[ch] ##1 !riseReg[ch]);
    c_abort: cover property (stateReg[ch] == spc_pkg::SPC_ST_RUN && stopCh[ch]);
  end
endmodule

/* File: sim/spc_drv_model.sv */
// external step/direction driver model: counts step pulses, keeps direction
`timescale 1ns/10ps
module spc_drv_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  // general outputs five to eight
  input  wire logic [3:0] pinIn
);
  int   pulses1 = 0;
  int   pulses2 = 0;
  logic dir1    = 1'b0;
  logic dir2    = 1'b0;
  logic prev1   = 1'b0;
  logic prev2   = 1'b0;
  // the real driver switches coil power; here only a rise counts, dir sampled there
  always @(posedge clk_sys) begin
    prev1 <= pinIn[1];
    prev2 <= pinIn[3];
    if (reset_n && pinIn[1] && !prev1) begin
      pulses1 <= pulses1 + 1;
      dir1    <= pinIn[0];
    end
    if (reset_n && pinIn[3] && !prev2) begin
      pulses2 <= pulses2 + 1;
      dir2    <= pinIn[2];
    end
  end
endmodule

/* File: sim/tb_top.sv */
// self-checking testbench of the stepper pulse controller
`timescale 1ns/10ps
module tb_top;
  logic                    clk_sys, reset_n, cmdValid, powerFailSense;
  spc_pkg::spc_op_t        cmdOp;
  logic [7:0]              cmdSel;
  logic signed [31:0]      cmdValue;
  logic [13:0]             cmdSpeed;
  logic [31:0]             cmdAccel;
  logic [3:0]              progOut;
  wire logic               cmdAck, cmdOk, isrStart, busyCh1, busyCh2, doneCh1, doneCh2;
  wire logic [3:0]         pinOut;
  wire logic [7:0]         isrSource, isrFunc;
  wire logic signed [31:0] absPosCh1, absPosCh2, relCountCh1, relCountCh2;
  int                      bad_count = 0;
  int                      compares = 0;
  int                      p0;
  int                      waitCycles;
  // a lower clock figure gives 5000 cycles a step at full rate, twice the pulse width
  spc_stepper_ctrl #(.CLK_HZ(32'd50000000)) i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdSel(cmdSel), .cmdValue(cmdValue),
    .cmdSpeed(cmdSpeed), .cmdAccel(cmdAccel), .cmdAck(cmdAck), .cmdOk(cmdOk),
    .progOut(progOut), .pinOut(pinOut), .powerFailSense(powerFailSense),
    .isrStart(isrStart), .isrSource(isrSource), .isrFunc(isrFunc), .busyCh1(busyCh1),
    .busyCh2(busyCh2), .doneCh1(doneCh1), .doneCh2(doneCh2), .absPosCh1(absPosCh1),
    .absPosCh2(absPosCh2), .relCountCh1(relCountCh1), .relCountCh2(relCountCh2));
  spc_drv_model i_drv (.clk_sys(clk_sys), .reset_n(reset_n), .pinIn(pinOut));
  task automatic close_out;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (exp !== got) begin
      bad_count++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic cmd(spc_pkg::spc_op_t op, logic [7:0] sel, logic [31:0] v, logic ok);
    @(posedge clk_sys);
    cmdValid <= 1'b1;
    cmdOp    <= op;
    cmdSel   <= sel;
    cmdValue <= v;
    @(posedge clk_sys);
    cmdValid <= 1'b0;
    #1;
    chk("cmdAck", 32'h1, {31'h0, cmdAck});
    chk("cmdOk", {31'h0, ok}, {31'h0, cmdOk});
  endtask
  // bounded wait for a done flag, then let the last pulse width run out
  task automatic waitDone(logic ch);
    int n;
    n = 0;
    while ((ch ? doneCh2 : doneCh1) !== 1'b1 && n < 40000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    waitCycles = n;
    if (n >= 40000) begin
      bad_count++;
      $display("mismatch done flag exp 1 got 0");
      close_out();
    end else begin
      repeat (3000) @(posedge clk_sys);
      #1;
    end
  endtask
  task automatic doReset;
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
  endtask
  task automatic t_power_fail;
    @(posedge clk_sys);
    powerFailSense <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("isrStart undefined", 32'h0, {31'h0, isrStart});
    powerFailSense <= 1'b0;
    cmd(spc_pkg::SPC_OP_INTR, 8'h12, 32'h2a, 1'b0);
    cmd(spc_pkg::SPC_OP_INTR, 8'h11, 32'h2a, 1'b1);
    @(posedge clk_sys);
    powerFailSense <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("isrStart", 32'h1, {31'h0, isrStart});
    chk("isrFunc", 32'h2a, {24'h0, isrFunc});
    chk("isrSource", 32'h11, {24'h0, isrSource});
    @(posedge clk_sys);
    #1;
    chk("isrStart width", 32'h0, {31'h0, isrStart});
  endtask
  task automatic t_half;
    cmd(spc_pkg::SPC_OP_SPEED, 8'h15, 32'h0, 1'b0);
    cmd(spc_pkg::SPC_OP_SPEED, 8'h03, 32'h0, 1'b0);
    cmd(spc_pkg::SPC_OP_SPEED, 8'h01, 32'h0, 1'b1);
    progOut <= 4'hf;
    cmd(spc_pkg::SPC_OP_REL, 8'h15, 32'h2, 1'b1);
    waitDone(1'b0);
    chk("coil pattern", 32'h2, {28'h0, pinOut});
    chk("half pos", 32'h2, absPosCh1);
    cmd(spc_pkg::SPC_OP_REL, 8'h0b, -32'sd1, 1'b1);
    waitDone(1'b0);
    chk("full coil", 32'h1, {28'h0, pinOut});
    chk("full pos", 32'h1, absPosCh1);
  endtask
  task automatic t_ctrl;
    // above the top rate: must clamp, or the steps come too fast
    cmdSpeed <= 14'h3fff;
    cmd(spc_pkg::SPC_OP_SPEED, 8'h01, 32'h0, 1'b1);
    cmd(spc_pkg::SPC_OP_SPEED, 8'h02, 32'h0, 1'b1);
    progOut <= 4'h0;
    p0 = i_drv.pulses1;
    cmd(spc_pkg::SPC_OP_REL, 8'h01, -32'sd3, 1'b1);
    chk("busy", 32'h1, {31'h0, busyCh1});
    chk("done clear", 32'h0, {31'h0, doneCh1});
    cmd(spc_pkg::SPC_OP_REL, 8'h01, 32'h5, 1'b0);
    progOut <= 4'hf;
    waitDone(1'b0);
    chk("pulses1", 32'd3, i_drv.pulses1 - p0);
    chk("dir1 neg", 32'h1, {31'h0, i_drv.dir1});
    chk("pos1", -32'sd3, absPosCh1);
    chk("rel1", -32'sd3, relCountCh1);
    // three intervals of 5000 cycles at the clamped top rate
    chk("step time", 32'h1, {31'h0, waitCycles > 14000 && waitCycles < 15500});
    chk("pulse pin owned", 32'h0, {31'h0, pinOut[1]});
    p0 = i_drv.pulses2;
    cmd(spc_pkg::SPC_OP_REL, 8'h20, 32'h2, 1'b1);
    chk("busy2", 32'h1, {31'h0, busyCh2});
    waitDone(1'b1);
    chk("pulses2", 32'd2, i_drv.pulses2 - p0);
    chk("dir2 pos", 32'h0, {31'h0, i_drv.dir2});
    chk("pos2", 32'h2, absPosCh2);
    chk("rel2", 32'h2, relCountCh2);
    cmd(spc_pkg::SPC_OP_REL, 8'h0b, 32'h1, 1'b0);
    p0 = i_drv.pulses1;
    cmd(spc_pkg::SPC_OP_ABS, 8'h01, 32'h1, 1'b1);
    waitDone(1'b0);
    chk("abs pulses", 32'd4, i_drv.pulses1 - p0);
    chk("abs dir", 32'h0, {31'h0, i_drv.dir1});
    chk("abs pos", 32'h1, absPosCh1);
    chk("abs rel", 32'h4, relCountCh1);
    cmd(spc_pkg::SPC_OP_ABS, 8'h01, 32'h64, 1'b1);
    chk("abs done clear", 32'h0, {31'h0, doneCh1});
    cmd(spc_pkg::SPC_OP_ABS, 8'h01, 32'h5, 1'b0);
    cmd(spc_pkg::SPC_OP_STOP, 8'h01, 32'h0, 1'b1);
    @(posedge clk_sys);
    #1;
    chk("stop idle", 32'h0, {31'h0, busyCh1});
    chk("stop done", 32'h0, {31'h0, doneCh1});
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    reset_n        = 1'b0;
    cmdValid       = 1'b0;
    cmdOp          = spc_pkg::SPC_OP_NONE;
    cmdSel         = 8'h00;
    cmdValue       = 32'h0;
    cmdSpeed       = 14'd10000;
    cmdAccel       = 32'h0;
    progOut        = 4'h0;
    powerFailSense = 1'b0;
    doReset();
    t_power_fail();
    t_half();
    doReset();
    t_ctrl();
    close_out();
  end
endmodule
